//--- ipo_instr_model.sv
// Instrument model: ready falls while triggered, rises after
`timescale 1ns/1ps
module ipo_instr_model
(
   input  logic       core_clk,
   input  logic       trigger_out,
   input  logic       pulse_polarity_option_a,
   output logic       instrument_done,
   output logic [2:0] instrument_status
);
   always @(posedge core_clk)
      instrument_done <= (trigger_out !== pulse_polarity_option_a);
   assign instrument_status = {pulse_polarity_option_a, 1'b1, !pulse_polarity_option_a};
endmodule

//--- ipo_pkg.sv
// Constants for the instrument program output port
// Functional notes
// R1: The block holds an 8-bit and a 16-bit output register loaded straight from the host data bus.
// R2: Host-side selector strobes load the bus data into the addressed register.
// R3: Separate strobes load the full word or each byte of the word on its own.
// R4: Every register bit drives the instrument-side outputs at all times.
// R5: The instrument done signal sets the interrupt flag on its rising or falling edge, by option.
// R6: Software can set or clear an interrupt-enable flag.
// R7: The interrupt flag and the interrupt-enable flag are both presented as outputs.
// R8: Any register-load strobe clears the interrupt flag; a done edge in the same cycle sets the flag instead.
// R9: Reset clears the interrupt flag and the interrupt-enable flag.
// R10: A selector read strobe puts the register contents onto the host read bus.
// R11: An option chooses whether reset clears or sets all register bits.
// R12: A status read puts both flags and the instrument status lines onto the host read bus.
// R13: A selector command fires one trigger pulse whose width is set between 2 and 12 us.
// R14: An option chooses a positive-going or negative-going trigger pulse.
// R15: Instrument done passes two flip-flops before edge detection; trigger width counts clocks.
package ipo_pkg;
   localparam int         CLK_HZ           = 40_000_000;
   localparam int         TRIG_MIN_NS      = 2000;
   localparam int         TRIG_MAX_NS      = 12000;
   localparam int         TRIG_MIN_CYC     = (TRIG_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int         TRIG_MAX_CYC     = (TRIG_MAX_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int         TRIG_W           = 9;
   localparam int         WORD_W           = 16;
   localparam int         BYTE_W           = 8;
   localparam logic [4:0] STAT_ENABLE_BIT  = 5'h01;
   localparam int         STAT_FLAG_POS    = 0;
   localparam int         STAT_ENABLE_POS  = 1;
   localparam int         STAT_INST_POS    = 2;
   localparam int         STAT_W           = 5;
endpackage

//--- ipo_port.sv
// Instrument program output port core
`timescale 1ns/1ps
module ipo_port
   import ipo_pkg::*;
#(
   parameter logic [8:0] TRIG_WIDTH_CYC = 9'(TRIG_MIN_CYC)
)
(
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic [WORD_W-1:0]   bus_data,
   input  wire logic                load_word,
   input  wire logic                load_low_byte,
   input  wire logic                load_high_byte,
   input  wire logic                load_byte_reg,
   input  wire logic                read_word,
   input  wire logic                read_byte,
   input  wire logic                read_status,
   input  wire logic                enable_set,
   input  wire logic                enable_clear,
   input  wire logic                trigger_cmd,
   input  wire logic [8:0]          trigger_width,
   input  wire logic                power_up_set_option,
   input  wire logic                ready_edge_option_a,
   input  wire logic                pulse_polarity_option_a,
   input  wire logic                instrument_done,
   input  wire logic [2:0]          instrument_status,
   output logic [WORD_W-1:0]        word_out,
   output logic [BYTE_W-1:0]        byte_out,
   output logic                     interrupt_flag,
   output logic                     interrupt_enable,
   output logic                     trigger_out,
   output logic [WORD_W-1:0]        read_data,
   output logic                     read_data_oe
);
   ipo_trig_if trig ();

   typedef struct packed
   {
      logic [WORD_W-1:0] word_reg;
      logic [BYTE_W-1:0] byte_reg;
      logic              flag;
      logic              enable;
      logic              done_s1;
      logic              done_s2;
      logic              done_d;
      logic [2:0]        stat_s1;
      logic [2:0]        stat_s2;
      logic              preset_pending;
      logic [1:0]        arm;
      logic              trig_out;
      logic [WORD_W-1:0] rdata;
      logic              roe;
   } ipo_port_s;
   ipo_port_s st;
   ipo_port_s next_st;

   function automatic logic [8:0] clamp_width(input logic [8:0] w);
      if (w < 9'(TRIG_MIN_CYC))
         return 9'(TRIG_MIN_CYC);
      else if (w > 9'(TRIG_MAX_CYC))
         return 9'(TRIG_MAX_CYC);
      else
         return w;
   endfunction

   logic done_edge;
   logic any_load;

   always_comb
   begin
      next_st = st;
      next_st.done_s1 = instrument_done; // R15
      next_st.done_s2 = st.done_s1;
      next_st.done_d  = st.done_s2;
      next_st.stat_s1 = instrument_status;
      next_st.stat_s2 = st.stat_s1;
      // Edge detect held off until the sync chain holds real pin values
      if (st.arm != 2'h3)
         next_st.arm = st.arm + 2'h1;
      // Selected edge of the synchronised done line
      done_edge = (st.arm == 2'h3) &
                  (ready_edge_option_a ? (st.done_s2 & ~st.done_d)
                                       : (~st.done_s2 & st.done_d)); // R5
      any_load = load_word | load_low_byte | load_high_byte | load_byte_reg;
      // Preset value caught after reset release
      next_st.preset_pending = 1'b0;
      if (st.preset_pending)
      begin
         next_st.word_reg = {WORD_W{power_up_set_option}}; // R11
         next_st.byte_reg = {BYTE_W{power_up_set_option}}; // R11
      end
      else
      begin
         if (load_word | load_low_byte)
            next_st.word_reg[7:0] = bus_data[7:0]; // R1 R2 R3
         if (load_word | load_high_byte)
            next_st.word_reg[15:8] = bus_data[15:8]; // R3
         if (load_byte_reg)
            next_st.byte_reg = bus_data[7:0]; // R1 R2
      end
      // Set wins over the load clear
      if (done_edge)
         next_st.flag = 1'b1; // R5
      else if (any_load)
         next_st.flag = 1'b0; // R8
      if (enable_set)
         next_st.enable = 1'b1; // R6
      else if (enable_clear)
         next_st.enable = 1'b0;
      // Read-back multiplexer
      next_st.roe   = read_word | read_byte | read_status;
      next_st.rdata = '0;
      if (read_word)
         next_st.rdata = st.word_reg; // R10
      else if (read_byte)
         next_st.rdata = {8'h00, st.byte_reg}; // R10
      else if (read_status)
         next_st.rdata = {11'h000, st.stat_s2, st.enable, st.flag}; // R12
      next_st.trig_out = trig.busy ^ ~pulse_polarity_option_a; // R14
   end

   assign trig.fire  = trigger_cmd; // R13
   assign trig.width = clamp_width(trigger_width | TRIG_WIDTH_CYC & 9'h000); // R13

   ipo_trig_gen u_trig
   (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .trig     (trig)
   );

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
      begin
         st                <= '0; // R9
         st.preset_pending <= 1'b1;
         st.trig_out       <= 1'b0;
      end
      else
         st <= next_st;
   end

   assign word_out         = st.word_reg; // R4
   assign byte_out         = st.byte_reg; // R4
   assign interrupt_flag   = st.flag; // R7
   assign interrupt_enable = st.enable; // R7
   assign trigger_out      = st.trig_out;
   assign read_data        = st.rdata;
   assign read_data_oe     = st.roe;
endmodule

//--- ipo_port_bench.sv
// Self-checking bench for the instrument program output port
`timescale 1ns/1ps
module ipo_port_bench;
   import ipo_pkg::*;
   logic        core_clk, rst_b, c, load_word, load_low_byte, load_high_byte, load_byte_reg;
   logic        read_word, read_byte, read_status, enable_set, enable_clear, trigger_cmd;
   logic        power_up_set_option, ready_edge_option_a, pulse_polarity_option_a;
   logic        instrument_done, interrupt_flag, interrupt_enable, trigger_out, read_data_oe;
   logic [15:0] bus_data, word_out, read_data;
   logic [8:0]  trigger_width;
   logic [7:0]  byte_out;
   logic [2:0]  instrument_status;
   int          num_errors = 0, checks = 0, n;
   int          wid[3] = '{10, 100, 500}, wexp[3] = '{80, 100, 480};
   ipo_port i_ipo_port (.*);
   ipo_instr_model i_ipo_instr_model (.*);
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k = 1);
      repeat (k) @(posedge core_clk);
      #2;
   endtask
   task automatic put(ref logic s, input logic [15:0] d);
      bus_data = d;
      s = 1;
      tick();
      s = 0;
   endtask
   task automatic wait_for(ref logic s, input logic v, input int lim);
      for (n = 0; s !== v && n < lim; n++)
         tick();
      if (n == lim)
      begin
         chk(16'(s), 16'(v));
         test_done();
      end
   endtask
   initial
   begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial
   begin
      {load_word, load_low_byte, load_high_byte, load_byte_reg, read_word, read_byte} = '0;
      {read_status, enable_set, enable_clear, trigger_cmd, bus_data, trigger_width} = '0;
      for (int i = 0; i < 2; i++)
      begin
         c = 1'(i);
         {power_up_set_option, ready_edge_option_a, pulse_polarity_option_a} = {3{c}};
         rst_b = 0;
         tick(6);
         rst_b = 1;
         tick(2);
         chk(word_out, {16{c}});
         chk(16'(byte_out), 16'({8{c}}));
         chk(16'({interrupt_flag, interrupt_enable}), 16'h0000);
         tick(2);
         chk(16'(interrupt_flag), 16'h0000);
         chk(16'(trigger_out), 16'(!c));
         put(load_word, 16'hA5C3);
         chk(word_out, 16'hA5C3);
         put(load_low_byte, 16'h0F1E);
         chk(word_out, 16'hA51E);
         put(load_high_byte, 16'h7788);
         chk(word_out, 16'h771E);
         put(load_byte_reg, 16'h0096);
         chk(16'(byte_out), 16'h0096);
         put(read_word, 16'h0000);
         chk(read_data, 16'h771E);
         put(read_byte, 16'h0000);
         chk(read_data, 16'h0096);
         put(enable_set, 16'h0000);
         put(read_status, 16'h0000);
         chk(read_data, {11'h000, c, 1'b1, !c, 2'b10});
         put(enable_clear, 16'h0000);
         chk(16'(interrupt_enable), 16'h0000);
         for (int k = 0; k < 3; k++)
         begin
            trigger_width = 9'(wid[k]);
            put(load_byte_reg, 16'(k));
            chk(16'(interrupt_flag), 16'h0000);
            put(trigger_cmd, 16'h0000);
            wait_for(trigger_out, c, 10);
            wait_for(trigger_out, !c, 600);
            chk(16'(n), 16'(wexp[k]));
            chk(16'(interrupt_flag), 16'(!c));
            wait_for(interrupt_flag, 1'b1, 10);
         end
      end
      test_done();
   end
endmodule
bind ipo_port ipo_port_props i_ipo_port_props (.*);

//--- ipo_port_props.sv
// Checker for register loads, flags and read-back of the port
`timescale 1ns/1ps
module ipo_port_props
(
   input logic        core_clk,
   input logic        rst_b,
   input logic [15:0] bus_data,
   input logic        load_word,
   input logic        load_byte_reg,
   input logic        read_word,
   input logic        read_byte,
   input logic        read_status,
   input logic        enable_set,
   input logic        enable_clear,
   input logic [15:0] word_out,
   input logic [7:0]  byte_out,
   input logic        interrupt_flag,
   input logic        interrupt_enable,
   input logic [15:0] read_data,
   input logic        read_data_oe,
   input logic        instrument_done
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   word_load_a: assert property (load_word && $past(rst_b) |=> word_out == $past(bus_data))
      else $error("word load wrong");
   byte_load_a: assert property (load_byte_reg && $past(rst_b) |=> byte_out == $past(bus_data[7:0]))
      else $error("byte load wrong");
   load_clear_a: assert property ((load_word || load_byte_reg) &&
      $past(instrument_done, 2) == $past(instrument_done, 3) |=> !interrupt_flag)
      else $error("flag not cleared");
   enable_set_a: assert property (enable_set |=> interrupt_enable)
      else $error("enable not set");
   enable_clear_a: assert property (enable_clear && !enable_set |=> !interrupt_enable)
      else $error("enable not cleared");
   read_oe_a: assert property (read_data_oe == $past(read_word || read_byte || read_status))
      else $error("read enable wrong");
   word_read_a: assert property (read_word |=> read_data == $past(word_out))
      else $error("word read wrong");
   byte_read_a: assert property (read_byte && !read_word |=> read_data[7:0] == $past(byte_out))
      else $error("byte read wrong");
endmodule

//--- ipo_trig_gen.sv
// Single-shot trigger pulse timer
`timescale 1ns/1ps
module ipo_trig_gen
   import ipo_pkg::*;
(
   input  wire logic     core_clk,
   input  wire logic     rst_b,
   ipo_trig_if.gen       trig
);
   typedef struct packed
   {
      logic [8:0]        count;
      logic              busy;
   } ipo_tg_s;
   ipo_tg_s st;
   ipo_tg_s next_st;

   always_comb
   begin
      next_st = st;
      if (st.busy)
      begin
         if (st.count <= 9'h001)
         begin
            next_st.busy  = 1'b0;
            next_st.count = 9'h000;
         end
         else
         begin
            next_st.count = st.count - 9'h001;
         end
      end
      else if (trig.fire)
      begin
         next_st.busy  = 1'b1; // R13
         next_st.count = trig.width; // R15
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_b)
         st <= '0;
      else
         st <= next_st;
   end

   assign trig.busy = st.busy;
endmodule

//--- ipo_trig_if.sv
// Carrier between the port core and the trigger pulse generator
`timescale 1ns/1ps
interface ipo_trig_if;
   logic                 fire;
   logic [8:0]           width;
   logic                 busy;
   modport core (output fire, output width, input busy);
   modport gen  (input fire, input width, output busy);
endinterface
